// ### hdl/dcr_pkg.sv
/*
 * Package for the two-instance converter control block: register map,
 * field positions, reset values and decoded carrier types.
 * Assumes an 8-bit register port on a single system clock.
 */
package dcr_pkg;

    // ==========================================================
    // register map
    localparam logic [11:0] DCR_ONE_CTRL_ADDR  = 12'h88C;
    localparam logic [11:0] DCR_ONE_LEVEL_ADDR = 12'h88D;
    localparam logic [11:0] DCR_TWO_CTRL_ADDR  = 12'h890;
    localparam logic [11:0] DCR_TWO_LEVEL_ADDR = 12'h891;
    localparam logic [7:0]  DCR_CTRL_RESET     = 8'h00;
    localparam logic [7:0]  DCR_LEVEL_RESET    = 8'h00;
    localparam logic [7:0]  DCR_UNMAPPED_READ  = 8'h00;

    // ==========================================================
    // control field positions
    localparam int DCR_EN_BIT    = 7;
    localparam int DCR_RANGE_BIT = 6;
    localparam int DCR_OE_HI     = 5;
    localparam int DCR_OE_LO     = 4;
    localparam int DCR_POSREF_HI  = 3;
    localparam int DCR_POSREF_LO  = 2;
    localparam int DCR_NEGREF_BIT = 0;

    // writable bits per instance; bit 1 never holds
    localparam logic [7:0] DCR_ONE_CTRL_MASK = 8'hFD;
    localparam logic [7:0] DCR_TWO_CTRL_MASK = 8'h8D;

    // level code at or above this picks the high buffer range
    localparam logic [7:0] DCR_AUTO_RANGE_THRESH = 8'h80;

    // ==========================================================
    // encodings
    typedef enum logic [1:0] {
        DCR_OE_NONE_A = 2'b00,
        DCR_OE_FIRST  = 2'b01,
        DCR_OE_SECOND = 2'b10,
        DCR_OE_NONE_B = 2'b11
    } dcr_oe_t;

    typedef enum logic [1:0] {
        DCR_PREF_SUPPLY = 2'b00,
        DCR_PREF_EXT    = 2'b01,
        DCR_PREF_FIXED  = 2'b10,
        DCR_PREF_RSVD   = 2'b11
    } dcr_pref_t;

    // decoded steering for one converter ladder
    typedef struct packed {
        logic       enable;
        logic       pref_supply;
        logic       pref_ext;
        logic       pref_fixed;
        logic       nref_ext;
        logic [7:0] level_code;
    } dcr_ladder_t;

endpackage

// ### hdl/dcr_top.sv
/*
 * Control logic for two 8-bit ladder converters: register file, reference
 * selects, pin enables and buffer range choice for the first instance.
 * Assumes a synchronous 8-bit register port and a sleep level from the
 * power controller, brought into the clock domain through a two-flop sync.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps

module dcr_top
    import dcr_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // device state and configuration
    input  wire logic        sleep_active,
    input  wire logic        auto_range_config_n,
    // first instance ladder and buffer
    output dcr_ladder_t      ladder_one,
    output logic             buffered_out_first,
    output logic             buffered_out_second,
    output logic             buffer_high_range,
    // second instance ladder, internal consumers only
    output dcr_ladder_t      ladder_two
);

    // ==========================================================
    // register file
    logic [7:0] one_ctrl_q, one_ctrl_d;
    logic [7:0] one_level_q, one_level_d;
    logic [7:0] two_ctrl_q, two_ctrl_d;
    logic [7:0] two_level_q, two_level_d;
    logic [7:0] rdata_d;

    // decoded ladder steering, shared by both instances
    function automatic dcr_ladder_t decode_ladder(input logic [7:0] ctrl,
                                                  input logic [7:0] level,
                                                  input logic       asleep);
        dcr_ladder_t l;
        dcr_pref_t   p;
        p             = dcr_pref_t'(ctrl[DCR_POSREF_HI:DCR_POSREF_LO]);
        l.enable      = ctrl[DCR_EN_BIT];
        // references dropped in sleep to save current
        l.pref_supply = !asleep && (p == DCR_PREF_SUPPLY);
        l.pref_ext    = !asleep && (p == DCR_PREF_EXT);
        l.pref_fixed  = !asleep && (p == DCR_PREF_FIXED);
        l.nref_ext    = !asleep && ctrl[DCR_NEGREF_BIT];
        l.level_code  = level;
        return l;
    endfunction

    always_comb
    begin
        one_ctrl_d  = one_ctrl_q;
        one_level_d = one_level_q;
        two_ctrl_d  = two_ctrl_q;
        two_level_d = two_level_q;
        // sleep does not touch the registers, so wake keeps them
        if (reg_wr)
        begin
            unique case (reg_addr)
                DCR_ONE_CTRL_ADDR:  one_ctrl_d  = reg_wdata & DCR_ONE_CTRL_MASK;
                DCR_ONE_LEVEL_ADDR: one_level_d = reg_wdata;
                DCR_TWO_CTRL_ADDR:  two_ctrl_d  = reg_wdata & DCR_TWO_CTRL_MASK;
                DCR_TWO_LEVEL_ADDR: two_level_d = reg_wdata;
                default:            ;
            endcase
        end
        rdata_d = DCR_UNMAPPED_READ;
        if (reg_rd)
        begin
            unique case (reg_addr)
                DCR_ONE_CTRL_ADDR:  rdata_d = one_ctrl_q;
                DCR_ONE_LEVEL_ADDR: rdata_d = one_level_q;
                DCR_TWO_CTRL_ADDR:  rdata_d = two_ctrl_q;
                DCR_TWO_LEVEL_ADDR: rdata_d = two_level_q;
                default:            rdata_d = DCR_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            one_ctrl_q  <= DCR_CTRL_RESET;
            one_level_q <= DCR_LEVEL_RESET;
            two_ctrl_q  <= DCR_CTRL_RESET;
            two_level_q <= DCR_LEVEL_RESET;
            reg_rdata   <= DCR_UNMAPPED_READ;
        end
        else
        begin
            one_ctrl_q  <= one_ctrl_d;
            one_level_q <= one_level_d;
            two_ctrl_q  <= two_ctrl_d;
            two_level_q <= two_level_d;
            reg_rdata   <= rdata_d;
        end
    end

    // ==========================================================
    // level inputs from outside the clock domain
    logic sleep_s1_q, sleep_s2_q;
    logic auto_s1_q, auto_s2_q;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
            auto_s1_q  <= 1'b0;
            auto_s2_q  <= 1'b0;
        end
        else
        begin
            sleep_s1_q <= sleep_active;
            sleep_s2_q <= sleep_s1_q;
            auto_s1_q  <= auto_range_config_n;
            auto_s2_q  <= auto_s1_q;
        end
    end

    // ==========================================================
    // decoded outputs, all registered
    dcr_ladder_t ladder_one_d, ladder_two_d;
    logic        out_first_d, out_second_d, high_range_d;
    dcr_oe_t     oe_sel;

    always_comb
    begin
        ladder_one_d = decode_ladder(one_ctrl_q, one_level_q, sleep_s2_q);
        ladder_two_d = decode_ladder(two_ctrl_q, two_level_q, sleep_s2_q);
        oe_sel       = dcr_oe_t'(one_ctrl_q[DCR_OE_HI:DCR_OE_LO]);
        // pins only carry the buffer while the converter runs
        out_first_d  = one_ctrl_q[DCR_EN_BIT] && (oe_sel == DCR_OE_FIRST);
        out_second_d = one_ctrl_q[DCR_EN_BIT] && (oe_sel == DCR_OE_SECOND);
        // the range bit exists only on the first instance's buffer
        if (auto_s2_q)
            high_range_d = one_ctrl_q[DCR_RANGE_BIT];
        else
            high_range_d = one_level_q >= DCR_AUTO_RANGE_THRESH;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ladder_one          <= '0;
            ladder_two          <= '0;
            buffered_out_first  <= 1'b0;
            buffered_out_second <= 1'b0;
            buffer_high_range   <= 1'b0;
        end
        else
        begin
            ladder_one          <= ladder_one_d;
            ladder_two          <= ladder_two_d;
            buffered_out_first  <= out_first_d;
            buffered_out_second <= out_second_d;
            buffer_high_range   <= high_range_d;
        end
    end

    // ==========================================================
    // checks
    property p_enable_follows;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == DCR_ONE_CTRL_ADDR) |=> ##1
            (ladder_one.enable == $past(reg_wdata[DCR_EN_BIT], 2));
    endproperty
    a_enable_follows: assert property (p_enable_follows)
        else $error("first enable does not follow write");

    property p_manual_range;
        @(posedge clock) disable iff (sys_rst)
        (auto_s2_q && $stable(one_ctrl_q)) |=>
            (buffer_high_range == $past(one_ctrl_q[DCR_RANGE_BIT]));
    endproperty
    a_manual_range: assert property (p_manual_range)
        else $error("manual range not taken from range bit");

    property p_auto_range;
        @(posedge clock) disable iff (sys_rst)
        !auto_s2_q |=> (buffer_high_range ==
            ($past(one_level_q) >= DCR_AUTO_RANGE_THRESH));
    endproperty
    a_auto_range: assert property (p_auto_range)
        else $error("auto range not taken from level code");

    property p_one_pin;
        @(posedge clock) disable iff (sys_rst)
        !(buffered_out_first && buffered_out_second);
    endproperty
    a_one_pin: assert property (p_one_pin)
        else $error("both output pins driven");

    property p_pin_decode;
        @(posedge clock) disable iff (sys_rst)
        (one_ctrl_q[DCR_OE_HI:DCR_OE_LO] == DCR_OE_NONE_B) |=>
            (!buffered_out_first && !buffered_out_second);
    endproperty
    a_pin_decode: assert property (p_pin_decode)
        else $error("pin driven with code 11");

    property p_sleep_ref;
        @(posedge clock) disable iff (sys_rst)
        sleep_s2_q |=> !(ladder_one.pref_supply || ladder_one.pref_ext ||
                         ladder_one.pref_fixed || ladder_one.nref_ext ||
                         ladder_two.pref_supply || ladder_two.pref_ext ||
                         ladder_two.pref_fixed || ladder_two.nref_ext);
    endproperty
    a_sleep_ref: assert property (p_sleep_ref)
        else $error("reference active during sleep");

    property p_two_mask;
        @(posedge clock) disable iff (sys_rst)
        (two_ctrl_q & ~DCR_TWO_CTRL_MASK) == 8'h00;
    endproperty
    a_two_mask: assert property (p_two_mask)
        else $error("unimplemented second control bits set");

    property p_sleep_keeps;
        @(posedge clock) disable iff (sys_rst)
        (sleep_s2_q && !reg_wr) |=> $stable(one_level_q) && $stable(two_ctrl_q);
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps)
        else $error("register changed in sleep without a write");

    property p_level_read;
        @(posedge clock) disable iff (sys_rst)
        (reg_rd && reg_addr == DCR_ONE_LEVEL_ADDR) |=> reg_rdata == $past(one_level_q);
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("level read back wrong");

    property p_first_pin;
        @(posedge clock) disable iff (sys_rst)
        (one_ctrl_q[DCR_EN_BIT] && one_ctrl_q[DCR_OE_HI:DCR_OE_LO] == DCR_OE_FIRST) |=>
            (buffered_out_first && !buffered_out_second);
    endproperty
    a_first_pin: assert property (p_first_pin)
        else $error("first pin not driven for code 01");

    property p_second_pin;
        @(posedge clock) disable iff (sys_rst)
        (one_ctrl_q[DCR_EN_BIT] && one_ctrl_q[DCR_OE_HI:DCR_OE_LO] == DCR_OE_SECOND) |=>
            (buffered_out_second && !buffered_out_first);
    endproperty
    a_second_pin: assert property (p_second_pin)
        else $error("second pin not driven for code 10");

    property p_disabled_pins;
        @(posedge clock) disable iff (sys_rst)
        !one_ctrl_q[DCR_EN_BIT] |=> !(buffered_out_first || buffered_out_second);
    endproperty
    a_disabled_pins: assert property (p_disabled_pins)
        else $error("pin driven while converter disabled");

    property p_enable_two;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == DCR_TWO_CTRL_ADDR) |=> ##1
            (ladder_two.enable == $past(reg_wdata[DCR_EN_BIT], 2));
    endproperty
    a_enable_two: assert property (p_enable_two)
        else $error("second enable does not follow write");

    property p_fixed_ref;
        @(posedge clock) disable iff (sys_rst)
        (!sleep_s2_q && one_ctrl_q[DCR_POSREF_HI:DCR_POSREF_LO] == DCR_PREF_FIXED) |=>
            (ladder_one.pref_fixed && !ladder_one.pref_supply && !ladder_one.pref_ext);
    endproperty
    a_fixed_ref: assert property (p_fixed_ref)
        else $error("fixed reference not selected for code 10");

    property p_reserved_ref;
        @(posedge clock) disable iff (sys_rst)
        (two_ctrl_q[DCR_POSREF_HI:DCR_POSREF_LO] == DCR_PREF_RSVD) |=>
            !(ladder_two.pref_supply || ladder_two.pref_ext || ladder_two.pref_fixed);
    endproperty
    a_reserved_ref: assert property (p_reserved_ref)
        else $error("reference selected for reserved code");

    property p_neg_ref;
        @(posedge clock) disable iff (sys_rst)
        !sleep_s2_q |=> (ladder_two.nref_ext == $past(two_ctrl_q[DCR_NEGREF_BIT]));
    endproperty
    a_neg_ref: assert property (p_neg_ref)
        else $error("second negative reference not from its bit");

    property p_reset_clears;
        @(posedge clock)
        sys_rst |=> (ladder_one == '0 && ladder_two == '0 &&
                     one_level_q == DCR_LEVEL_RESET && two_level_q == DCR_LEVEL_RESET &&
                     !buffered_out_first && !buffered_out_second);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left converter state behind");

endmodule

// ### dv/dcr_top_tb.sv
/*
 * Self-checking bench for dcr_top: reset values, a table of control settings,
 * then unmapped access, second instance, sleep and mid-run reset cases.
 * Assumes the register port timing and input sync delays of dcr_top.
 */
`timescale 1ns/1ps

module dcr_top_tb
    import dcr_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    logic        clock               = 1'b0;
    logic        sys_rst             = 1'b1;
    logic [11:0] reg_addr            = 12'h000;
    logic [7:0]  reg_wdata           = 8'h00;
    logic        reg_wr              = 1'b0;
    logic        reg_rd              = 1'b0;
    logic        sleep_active        = 1'b0;
    logic        auto_range_config_n = 1'b1;
    logic [7:0]  reg_rdata;
    dcr_ladder_t ladder_one;
    dcr_ladder_t ladder_two;
    logic        out_first;
    logic        out_second;
    logic        high_range;
    int          failures            = 0;
    int          comparisons         = 0;

    // flags are {enable, supply, ext, fixed, nref}; pins {first, second, high}
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] lvl;
        logic       man;
        logic [4:0] flags;
        logic [2:0] pins;
    } dcr_row_t;

    dcr_row_t rows [7] = '{
        '{8'h80, 8'h00, 1'b1, 5'b11000, 3'b000},
        '{8'hD7, 8'h10, 1'b1, 5'b10101, 3'b101},
        '{8'hA8, 8'hFF, 1'b1, 5'b10010, 3'b010},
        '{8'hBC, 8'h00, 1'b1, 5'b10000, 3'b000},
        '{8'h10, 8'h00, 1'b1, 5'b01000, 3'b000},
        '{8'h91, 8'h80, 1'b0, 5'b11001, 3'b101},
        '{8'hD1, 8'h7F, 1'b0, 5'b11001, 3'b100}
    };

    always #50 clock = ~clock;

    dcr_top i_dcr_top (
        .clock               (clock),
        .sys_rst             (sys_rst),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .sleep_active        (sleep_active),
        .auto_range_config_n (auto_range_config_n),
        .ladder_one          (ladder_one),
        .buffered_out_first  (out_first),
        .buffered_out_second (out_second),
        .buffer_high_range   (high_range),
        .ladder_two          (ladder_two)
    );

    // ==========================================================
    // compare and bus tasks
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_lad(input string name, input dcr_ladder_t exp, input dcr_ladder_t got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_one(input logic [4:0] fl, input logic [7:0] lvl, input logic [2:0] pins);
        chk_lad("ladder one", {fl, lvl}, ladder_one);
        chk1("first pin", pins[2], out_first);
        chk1("second pin", pins[1], out_second);
        chk1("high range", pins[0], high_range);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // read data stands one cycle only, then returns to zero
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk8("read data", exp, reg_rdata);
        @(posedge clock);
        #1;
        chk8("idle read data", 8'h00, reg_rdata);
    endtask

    // covers the two-flop input sync plus the output register
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk_one(5'b00000, 8'h00, 3'b000);
        chk_lad("ladder two", {5'b00000, 8'h00}, ladder_two);
        rd(DCR_ONE_CTRL_ADDR, 8'h00);
        rd(DCR_ONE_LEVEL_ADDR, 8'h00);
        rd(DCR_TWO_CTRL_ADDR, 8'h00);
        rd(DCR_TWO_LEVEL_ADDR, 8'h00);
        foreach (rows[i])
        begin
            @(posedge clock);
            auto_range_config_n <= rows[i].man;
            wr(DCR_ONE_CTRL_ADDR, rows[i].ctrl);
            wr(DCR_ONE_LEVEL_ADDR, rows[i].lvl);
            settle();
            chk_one(rows[i].flags, rows[i].lvl, rows[i].pins);
            rd(DCR_ONE_CTRL_ADDR, rows[i].ctrl & 8'hFD);
            rd(DCR_ONE_LEVEL_ADDR, rows[i].lvl);
        end
        wr(12'h88E, 8'hFF);
        rd(12'h88E, 8'h00);
        rd(DCR_ONE_CTRL_ADDR, 8'hD1);
        wr(DCR_TWO_CTRL_ADDR, 8'hFF);
        wr(DCR_TWO_LEVEL_ADDR, 8'h5A);
        settle();
        chk_lad("ladder two", {5'b10001, 8'h5A}, ladder_two);
        rd(DCR_TWO_CTRL_ADDR, 8'h8D);
        chk_one(5'b11001, 8'h7F, 3'b100);
        wr(DCR_TWO_CTRL_ADDR, 8'h89);
        settle();
        chk_lad("ladder two", {5'b10011, 8'h5A}, ladder_two);
        @(posedge clock);
        sleep_active <= 1'b1;
        settle();
        chk_one(5'b10000, 8'h7F, 3'b100);
        chk_lad("ladder two", {5'b10000, 8'h5A}, ladder_two);
        @(posedge clock);
        sleep_active <= 1'b0;
        settle();
        chk_one(5'b11001, 8'h7F, 3'b100);
        rd(DCR_ONE_CTRL_ADDR, 8'hD1);
        rd(DCR_TWO_LEVEL_ADDR, 8'h5A);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk_one(5'b00000, 8'h00, 3'b000);
        chk_lad("ladder two", {5'b00000, 8'h00}, ladder_two);
        rd(DCR_ONE_LEVEL_ADDR, 8'h00);
        rd(DCR_TWO_CTRL_ADDR, 8'h00);
        complete_run();
    end

    // hang guard: a run this long counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        complete_run();
    end

endmodule
